/* rtl/bfs_consts.svh */
/*
  register map, field positions, reset values and codes of the breaker
  failure supervisor; assumes inclusion by its bare name from the package
  and the design modules, which all share one 32-bit register bus
*/
// Overview of operation
// - breaker failure lockout stays latched once set
// - lockout drives a close-inhibit output
// - trigger class: all, current or external trips
// - position and combined schemes need closed breaker
// - current scheme starts regardless of breaker position
// - open position stops timer; combined also needs undercurrent
// - current scheme stops timer on undercurrent
// - rejected until the selected trigger drops, then stand-by
// - timer expiry asserts the upstream backup trip
// - trip released when triggers drop and clear holds
// - timer keeps running after trigger drops
// - lockout held until operator acknowledgement or element deactivation
`ifndef BFS_CONSTS_SVH
`define BFS_CONSTS_SVH
`define BFS_DATA_W 32
`define BFS_ADDR_W 8
// register byte offsets
`define BFS_OFS_CTRL 8'h00
`define BFS_OFS_DELAY 8'h04
`define BFS_OFS_THRESH 8'h08
`define BFS_OFS_STATUS 8'h0c
`define BFS_OFS_IRQ_STAT 8'h10
`define BFS_OFS_IRQ_MASK 8'h14
`define BFS_OFS_TIMER 8'h18
// control fields
`define BFS_CTRL_USE 0
`define BFS_CTRL_ASSIGNED 1
`define BFS_CTRL_SCHEME 3:2
`define BFS_CTRL_TRIG 5:4
`define BFS_CTRL_RST 32'h0000_0000
`define BFS_DELAY_RST 32'h0000_0064
`define BFS_THRESH_RST 32'h0000_0000
// status fields
`define BFS_STAT_STATE 1:0
`define BFS_STAT_TRIP 2
`define BFS_STAT_LOCK 3
`define BFS_STAT_UNDER 4
`define BFS_STAT_TRIG 5
// event bits
`define BFS_IRQ_W 3
`define BFS_IRQ_START 0
`define BFS_IRQ_REJECT 1
`define BFS_IRQ_FAIL 2
// codes
`define BFS_SCH_POS 2'h0
`define BFS_SCH_CUR 2'h1
`define BFS_SCH_BOTH 2'h2
`define BFS_TRG_NONE 2'h0
`define BFS_TRG_ALL 2'h1
`define BFS_TRG_CUR 2'h2
`define BFS_TRG_EXT 2'h3
`define BFS_ST_STANDBY 2'h0
`define BFS_ST_RUN 2'h1
`define BFS_ST_FAIL 2'h3
`define BFS_ST_REJECT 2'h2
`define BFS_RESP_OKAY 2'h0
`define BFS_RESP_SLVERR 2'h2
`endif

/* rtl/bfs_pkg.sv */
/*
  types of the breaker failure supervisor: states, bus carriers, trips;
  assumes the constants header is on the include path
*/
`include "bfs_consts.svh"
package bfs_pkg;
   // element state, gray along stand-by, running, failed
   typedef enum logic [1:0] {
      BFS_STANDBY = `BFS_ST_STANDBY,
      BFS_RUNNING = `BFS_ST_RUN,
      BFS_FAILED = `BFS_ST_FAIL,
      BFS_REJECTED = `BFS_ST_REJECT
   } bfs_state_type;
   // trip source classes offered by the trip manager
   typedef struct packed {
      logic external_trips;
      logic current_trips;
      logic all_trips;
   } bfs_trips_type;
   // axi4-lite master to slave
   typedef struct packed {
      logic [`BFS_ADDR_W-1:0] awaddr;
      logic awvalid;
      logic [`BFS_DATA_W-1:0] wdata;
      logic [`BFS_DATA_W/8-1:0] wstrb;
      logic wvalid;
      logic bready;
      logic [`BFS_ADDR_W-1:0] araddr;
      logic arvalid;
      logic rready;
   } bfs_axil_req_type;
   // axi4-lite slave to master
   typedef struct packed {
      logic awready;
      logic wready;
      logic bvalid;
      logic [1:0] bresp;
      logic arready;
      logic rvalid;
      logic [`BFS_DATA_W-1:0] rdata;
      logic [1:0] rresp;
   } bfs_axil_rsp_type;
endpackage

/* rtl/bfs_timer.sv */
/*
  supervision delay counter clocked by the sampling tick;
  assumes a one-cycle tick pulse synchronous to the clock
*/
`timescale 1ns/1ps
`default_nettype none
module bfs_timer #(
   parameter int DELAY_W = 16
) (
   // clock and control
   input wire logic i_ref_clk,
   input wire logic i_srst,
   input wire logic i_ce,
   // load and count
   input wire logic i_load,
   input wire logic [DELAY_W-1:0] i_load_val,
   input wire logic i_run,
   input wire logic i_tick,
   // state
   output logic [DELAY_W-1:0] o_count,
   output logic o_expired
);
   // counts down on ticks only, so the delay is in tick periods
   always_ff @(posedge i_ref_clk)
   begin
      if (i_srst)
         o_count <= '0;
      else if (i_ce)
      begin
         if (i_load)
            o_count <= i_load_val;
         else if (i_run && i_tick && (o_count != '0))
            o_count <= o_count - 1'b1;
      end
   end
   // zero is expiry; a zero delay expires on the first running cycle
   assign o_expired = (o_count == '0);
endmodule
`default_nettype wire

/* rtl/bfs_sticky.sv */
/*
  sticky event bits with write-one-to-clear, mask and level interrupt;
  assumes set and clear pulses from the same clock domain
*/
`timescale 1ns/1ps
`default_nettype none
module bfs_sticky #(
   parameter int W = 3
) (
   // clock and control
   input wire logic i_ref_clk,
   input wire logic i_srst,
   input wire logic i_ce,
   // events and software access
   input wire logic [W-1:0] i_set,
   input wire logic [W-1:0] i_clr,
   input wire logic i_mask_we,
   input wire logic [W-1:0] i_mask_wdata,
   // state
   output logic [W-1:0] o_status,
   output logic [W-1:0] o_mask,
   output logic o_irq
);
   logic [W-1:0] next_status; // status after this cycle
   // a set arriving with its clear wins, so no event is lost
   assign next_status = (o_status & ~i_clr) | i_set;
   // status, mask and interrupt level, all registered
   always_ff @(posedge i_ref_clk)
   begin
      if (i_srst)
      begin
         o_status <= '0;
         o_mask <= '0;
         o_irq <= 1'b0;
      end
      else if (i_ce)
      begin
         o_status <= next_status;
         if (i_mask_we)
            o_mask <= i_mask_wdata;
         // uses the next status so the line tracks the bits without lag
         o_irq <= |(next_status & (i_mask_we ? i_mask_wdata : o_mask));
      end
   end
endmodule
`default_nettype wire

/* rtl/bfs_top.sv */
/*
  breaker failure supervisor: trigger selection, supervision timer,
  stop, reject and failure states, latched lockout, axi4-lite registers;
  assumes trips, position, current and tick synchronous to i_ref_clk
*/
`timescale 1ns/1ps
`default_nettype none
`include "bfs_consts.svh"
module bfs_top #(
   parameter int DELAY_W = 16,
   parameter int CUR_W = 16
) (
   // clock, reset, enable
   input wire logic i_ref_clk,
   input wire logic i_srst,
   input wire logic i_ce,
   // register bus
   input wire bfs_pkg::bfs_axil_req_type i_axil,
   output bfs_pkg::bfs_axil_rsp_type o_axil,
   // trip sources and breaker
   input wire bfs_pkg::bfs_trips_type i_trips,
   input wire logic i_tick,
   input wire logic i_brk_open,
   input wire logic i_brk_closed,
   input wire logic [CUR_W-1:0] i_current,
   input wire logic i_lockout_ack,
   // protection outputs
   output logic o_backup_trip,
   output logic o_close_inhibit,
   output logic o_irq
);
   import bfs_pkg::*;

   // configuration registers
   logic [`BFS_DATA_W-1:0] ctrl; // use, assigned, scheme, trigger
   logic [DELAY_W-1:0] supervision_delay; // in sampling ticks
   logic [CUR_W-1:0] under_thresh; // undercurrent threshold
   // element state
   bfs_state_type state;
   bfs_state_type next_state;
   // derived conditions
   logic active; // element in use and assigned
   logic trig; // selected trigger class present
   logic under; // current below threshold
   logic stop; // scheme's stop and clear condition
   logic start_ok; // start condition in stand-by
   // timer
   logic [DELAY_W-1:0] timer_count;
   logic timer_expired;
   // events
   logic [`BFS_IRQ_W-1:0] ev_set;
   logic [`BFS_IRQ_W-1:0] ev_clr;
   logic [`BFS_IRQ_W-1:0] irq_status;
   logic [`BFS_IRQ_W-1:0] irq_mask;
   logic mask_we;
   // bus write path
   logic [`BFS_ADDR_W-1:0] aw_addr;
   logic aw_held;
   logic [`BFS_DATA_W-1:0] w_data;
   logic [`BFS_DATA_W/8-1:0] w_strb;
   logic w_held;
   logic do_write; // both halves present, response slot free
   logic [`BFS_DATA_W-1:0] wmask; // byte enables as bit mask
   logic [`BFS_DATA_W-1:0] rd_word;
   logic rd_hit;
   logic wr_hit;

   // unused, or no breaker assigned, keeps the element idle
   assign active = ctrl[`BFS_CTRL_USE] && ctrl[`BFS_CTRL_ASSIGNED];
   assign under = (i_current < under_thresh);

   // trigger class select
   always_comb
   begin
      unique case (ctrl[`BFS_CTRL_TRIG])
         `BFS_TRG_ALL: trig = i_trips.all_trips;
         `BFS_TRG_CUR: trig = i_trips.current_trips;
         `BFS_TRG_EXT: trig = i_trips.external_trips;
         default: trig = 1'b0; // none selected
      endcase
   end

   // stop condition doubles as the trip clear condition
   always_comb
   begin
      unique case (ctrl[`BFS_CTRL_SCHEME])
         `BFS_SCH_POS: stop = i_brk_open;
         `BFS_SCH_CUR: stop = under;
         `BFS_SCH_BOTH: stop = i_brk_open && under;
         default: stop = i_brk_open; // reserved code acts as position
      endcase
   end

   // position check skipped only in the current scheme
   always_comb
   begin
      if (ctrl[`BFS_CTRL_SCHEME] == `BFS_SCH_CUR)
         start_ok = trig;
      else
         start_ok = trig && i_brk_closed;
   end

   // next state of the element
   always_comb
   begin
      next_state = state;
      unique case (state)
         BFS_STANDBY:
         begin
            if (start_ok)
               next_state = BFS_RUNNING;
         end
         BFS_RUNNING:
         begin
            // trigger drop is ignored here; stop beats a same-cycle expiry
            if (stop)
               next_state = BFS_REJECTED;
            else if (timer_expired)
               next_state = BFS_FAILED;
         end
         BFS_REJECTED:
         begin
            if (!trig)
               next_state = BFS_STANDBY;
         end
         BFS_FAILED:
         begin
            if (!trig && stop)
               next_state = BFS_STANDBY;
         end
      endcase
      if (!active)
         next_state = BFS_STANDBY;
   end

   // state register
   always_ff @(posedge i_ref_clk)
   begin
      if (i_srst)
         state <= BFS_STANDBY;
      else if (i_ce)
         state <= next_state;
   end

   // supervision timer, loaded on entry to running
   bfs_timer #(
      .DELAY_W(DELAY_W)
   ) u_timer (
      .i_ref_clk(i_ref_clk),
      .i_srst(i_srst),
      .i_ce(i_ce),
      .i_load(state == BFS_STANDBY),
      .i_load_val(supervision_delay),
      .i_run(state == BFS_RUNNING),
      .i_tick(i_tick),
      .o_count(timer_count),
      .o_expired(timer_expired)
   );

   // upstream backup trip follows the failed state
   always_ff @(posedge i_ref_clk)
   begin
      if (i_srst)
         o_backup_trip <= 1'b0;
      else if (i_ce)
         o_backup_trip <= (next_state == BFS_FAILED);
   end

   // latched lockout: set with the trip, held until acknowledged or the element goes inactive
   always_ff @(posedge i_ref_clk)
   begin
      if (i_srst)
         o_close_inhibit <= 1'b0;
      else if (i_ce)
      begin
         if (!active)
            o_close_inhibit <= 1'b0;
         else if (next_state == BFS_FAILED)
            o_close_inhibit <= 1'b1;
         else if (i_lockout_ack)
            o_close_inhibit <= 1'b0;
      end
   end

   // events: timer start, rejection, breaker failure
   always_comb
   begin
      ev_set = '0;
      ev_set[`BFS_IRQ_START] = (state == BFS_STANDBY) && (next_state == BFS_RUNNING);
      ev_set[`BFS_IRQ_REJECT] = (state == BFS_RUNNING) && (next_state == BFS_REJECTED);
      ev_set[`BFS_IRQ_FAIL] = (state == BFS_RUNNING) && (next_state == BFS_FAILED);
   end

   assign ev_clr = (do_write && (aw_addr == `BFS_OFS_IRQ_STAT))
      ? w_data[`BFS_IRQ_W-1:0] & wmask[`BFS_IRQ_W-1:0] : '0;
   assign mask_we = do_write && (aw_addr == `BFS_OFS_IRQ_MASK);

   bfs_sticky #(
      .W(`BFS_IRQ_W)
   ) u_sticky (
      .i_ref_clk(i_ref_clk),
      .i_srst(i_srst),
      .i_ce(i_ce),
      .i_set(ev_set),
      .i_clr(ev_clr),
      .i_mask_we(mask_we),
      .i_mask_wdata((irq_mask & ~wmask[`BFS_IRQ_W-1:0])
         | (w_data[`BFS_IRQ_W-1:0] & wmask[`BFS_IRQ_W-1:0])),
      .o_status(irq_status),
      .o_mask(irq_mask),
      .o_irq(o_irq)
   );

   // byte enables widened to a bit mask
   always_comb
   begin
      wmask = '0;
      for (int i = 0; i < `BFS_DATA_W / 8; i++)
      begin
         wmask[i*8 +: 8] = {8{w_strb[i]}};
      end
   end

   assign do_write = aw_held && w_held && !o_axil.bvalid;

   // write address and data taken independently, in either order
   always_ff @(posedge i_ref_clk)
   begin
      if (i_srst)
      begin
         aw_held <= 1'b0;
         w_held <= 1'b0;
         aw_addr <= '0;
         w_data <= '0;
         w_strb <= '0;
         o_axil.awready <= 1'b1;
         o_axil.wready <= 1'b1;
      end
      else if (i_ce)
      begin
         if (i_axil.awvalid && o_axil.awready)
         begin
            aw_addr <= i_axil.awaddr;
            aw_held <= 1'b1;
            o_axil.awready <= 1'b0;
         end
         else if (do_write)
            aw_held <= 1'b0;
         if (i_axil.wvalid && o_axil.wready)
         begin
            w_data <= i_axil.wdata;
            w_strb <= i_axil.wstrb;
            w_held <= 1'b1;
            o_axil.wready <= 1'b0;
         end
         else if (do_write)
            w_held <= 1'b0;
         // ready again only once the response has been taken
         if (o_axil.bvalid && i_axil.bready)
         begin
            o_axil.awready <= 1'b1;
            o_axil.wready <= 1'b1;
         end
      end
   end

   // write hit decode; read-only and unmapped offsets answer slverr
   always_comb
   begin
      unique case (aw_addr)
         `BFS_OFS_CTRL, `BFS_OFS_DELAY, `BFS_OFS_THRESH,
         `BFS_OFS_IRQ_STAT, `BFS_OFS_IRQ_MASK: wr_hit = 1'b1;
         default: wr_hit = 1'b0;
      endcase
   end

   // write response
   always_ff @(posedge i_ref_clk)
   begin
      if (i_srst)
      begin
         o_axil.bvalid <= 1'b0;
         o_axil.bresp <= `BFS_RESP_OKAY;
      end
      else if (i_ce)
      begin
         if (do_write)
         begin
            o_axil.bvalid <= 1'b1;
            o_axil.bresp <= wr_hit ? `BFS_RESP_OKAY : `BFS_RESP_SLVERR;
         end
         else if (i_axil.bready)
            o_axil.bvalid <= 1'b0;
      end
   end

   // configuration registers, byte-lane merged
   always_ff @(posedge i_ref_clk)
   begin
      if (i_srst)
      begin
         ctrl <= `BFS_CTRL_RST;
         supervision_delay <= DELAY_W'(`BFS_DELAY_RST);
         under_thresh <= CUR_W'(`BFS_THRESH_RST);
      end
      else if (i_ce && do_write)
      begin
         if (aw_addr == `BFS_OFS_CTRL)
            ctrl <= (ctrl & ~wmask) | (w_data & wmask);
         if (aw_addr == `BFS_OFS_DELAY)
            supervision_delay <= (supervision_delay & ~wmask[DELAY_W-1:0])
               | (w_data[DELAY_W-1:0] & wmask[DELAY_W-1:0]);
         if (aw_addr == `BFS_OFS_THRESH)
            under_thresh <= (under_thresh & ~wmask[CUR_W-1:0])
               | (w_data[CUR_W-1:0] & wmask[CUR_W-1:0]);
      end
   end

   // read mux
   always_comb
   begin
      rd_word = '0;
      rd_hit = 1'b1;
      unique case (i_axil.araddr)
         `BFS_OFS_CTRL: rd_word = ctrl;
         `BFS_OFS_DELAY: rd_word[DELAY_W-1:0] = supervision_delay;
         `BFS_OFS_THRESH: rd_word[CUR_W-1:0] = under_thresh;
         `BFS_OFS_STATUS:
         begin
            rd_word[`BFS_STAT_STATE] = state;
            rd_word[`BFS_STAT_TRIP] = o_backup_trip;
            rd_word[`BFS_STAT_LOCK] = o_close_inhibit;
            rd_word[`BFS_STAT_UNDER] = under;
            rd_word[`BFS_STAT_TRIG] = trig;
         end
         `BFS_OFS_IRQ_STAT: rd_word[`BFS_IRQ_W-1:0] = irq_status;
         `BFS_OFS_IRQ_MASK: rd_word[`BFS_IRQ_W-1:0] = irq_mask;
         `BFS_OFS_TIMER: rd_word[DELAY_W-1:0] = timer_count;
         default: rd_hit = 1'b0; // unmapped
      endcase
   end

   // read channel: one read in flight, answer one cycle after the address
   always_ff @(posedge i_ref_clk)
   begin
      if (i_srst)
      begin
         o_axil.arready <= 1'b1;
         o_axil.rvalid <= 1'b0;
         o_axil.rdata <= '0;
         o_axil.rresp <= `BFS_RESP_OKAY;
      end
      else if (i_ce)
      begin
         if (i_axil.arvalid && o_axil.arready)
         begin
            o_axil.arready <= 1'b0;
            o_axil.rvalid <= 1'b1;
            o_axil.rdata <= rd_word;
            o_axil.rresp <= rd_hit ? `BFS_RESP_OKAY : `BFS_RESP_SLVERR;
         end
         else if (o_axil.rvalid && i_axil.rready)
         begin
            o_axil.rvalid <= 1'b0;
            o_axil.arready <= 1'b1;
         end
      end
   end
endmodule
`default_nettype wire

/* verif/bfs_top_sva.sv */
/*
  port checker of the breaker failure supervisor top;
  assumes binding from the bench top, one clock, clock enable held high
*/
`timescale 1ns/1ps
`default_nettype none
module bfs_top_sva (
   // clock and reset
   input wire logic i_ref_clk,
   input wire logic i_srst,
   input wire logic i_ce,
   // register bus
   input wire bfs_pkg::bfs_axil_req_type i_axil,
   input wire bfs_pkg::bfs_axil_rsp_type o_axil,
   // protection side
   input wire bfs_pkg::bfs_trips_type i_trips,
   input wire logic i_lockout_ack,
   input wire logic o_backup_trip,
   input wire logic o_close_inhibit,
   input wire logic o_irq
);
   import bfs_pkg::*;
   default clocking @(posedge i_ref_clk); endclocking
   default disable iff (i_srst);
   // lockout comes up with the trip, never later
   a_lock_with_trip: assert property ($rose(o_backup_trip) |-> o_close_inhibit)
      else $error("lockout missing at trip");
   // only acknowledge, reset or a recent write response may drop the lockout
   a_lock_held: assert property ($fell(o_close_inhibit) |-> $past(i_lockout_ack)
      || $past(i_srst) || $past(o_axil.bvalid))
      else $error("lockout dropped without cause");
   // every class raised means the selected trigger is still present
   a_trip_held: assert property ($fell(o_backup_trip) |-> $past(i_trips) != 3'h7
      || $past(i_srst) || $past(o_axil.bvalid))
      else $error("trip released with trigger present");
   a_reset_quiet: assert property ($past(i_srst) && $past(i_ce) |->
      !o_backup_trip && !o_close_inhibit && !o_irq)
      else $error("outputs active after reset");
   a_wr_answer: assert property (i_ce && i_axil.awvalid && o_axil.awready && i_axil.wvalid
      && o_axil.wready |-> ##2 o_axil.bvalid)
      else $error("write response late");
   a_rd_answer: assert property (i_ce && i_axil.arvalid && o_axil.arready |=>
      o_axil.rvalid && !o_axil.arready)
      else $error("read response late");
   a_w_refused: assert property (o_axil.bvalid |-> !o_axil.awready && !o_axil.wready)
      else $error("write taken while response pending");
   a_ar_refused: assert property (o_axil.rvalid |-> !o_axil.arready)
      else $error("read taken while data pending");
   a_b_once: assert property (i_ce && o_axil.bvalid && i_axil.bready |=> !o_axil.bvalid)
      else $error("write response repeated");
endmodule
`default_nettype wire

/* verif/bfs_plant_model.sv */
/*
  trip sources and supervised breaker: registered trips, free sampling tick,
  contacts that travel with both indicators low; assumes one clock
*/
`timescale 1ns/1ps
`default_nettype none
module bfs_plant_model #(
   parameter int TICK_DIV = 4,
   parameter int TRAVEL = 3
) (
   // clock and reset
   input wire logic i_ref_clk,
   input wire logic i_srst,
   // commands from the bench
   input wire logic [2:0] i_cmd_trips,
   input wire logic i_cmd_open,
   input wire logic [15:0] i_cmd_amps,
   // toward the supervisor
   output bfs_pkg::bfs_trips_type o_trips,
   output logic o_tick,
   output logic o_brk_open,
   output logic o_brk_closed,
   output logic [15:0] o_current
);
   import bfs_pkg::*;
   int div = 0; // tick divider
   int travel = 0; // cycles of contact motion left
   logic pos_open = 1'b0; // settled contact position
   // trips and current pass one register, as a relay front end would
   always_ff @(posedge i_ref_clk)
   begin
      o_trips <= bfs_trips_type'(i_cmd_trips);
      o_current <= i_cmd_amps;
      div <= (i_srst || div == TICK_DIV - 1) ? 0 : div + 1;
      o_tick <= (div == TICK_DIV - 1);
   end
   // contacts: no indicator is trustworthy while moving
   always_ff @(posedge i_ref_clk)
   begin
      if (i_srst)
         travel <= 0;
      else if (travel != 0)
         travel <= travel - 1;
      else if (i_cmd_open != pos_open)
         travel <= TRAVEL;
      if (travel == 1)
         pos_open <= i_cmd_open;
   end
   assign o_brk_open = pos_open && travel == 0;
   assign o_brk_closed = !pos_open && travel == 0;
endmodule
`default_nettype wire

/* verif/bfs_top_tb_top.sv */
/*
  self-checking bench of the breaker failure supervisor top;
  assumes the package, the plant model and the checker are compiled first
*/
`timescale 1ns/1ps
`default_nettype none
`include "bfs_consts.svh"
module bfs_top_tb_top;
   import bfs_pkg::*;
   localparam int LIMIT = 5000; // whole run is under 1500 cycles
   logic i_ref_clk = 1'b0;
   logic i_srst = 1'b1;
   bfs_axil_req_type axil = '0;
   bfs_axil_rsp_type rsp;
   bfs_trips_type trips;
   logic [2:0] cmd_trips = 3'h0;
   logic cmd_open = 1'b0, ack = 1'b0;
   logic tick, brk_open, brk_closed, trip, inhibit, irq;
   logic [15:0] cmd_amps = 16'h0000, amps;
   int failures = 0, checked = 0, cycles = 0;
   always #20 i_ref_clk = ~i_ref_clk;
   bfs_top i_dut (.i_ref_clk(i_ref_clk), .i_srst(i_srst), .i_ce(1'b1), .i_axil(axil),
      .o_axil(rsp), .i_trips(trips), .i_tick(tick), .i_brk_open(brk_open),
      .i_brk_closed(brk_closed), .i_current(amps), .i_lockout_ack(ack),
      .o_backup_trip(trip), .o_close_inhibit(inhibit), .o_irq(irq));
   bfs_plant_model i_plant (.i_ref_clk(i_ref_clk), .i_srst(i_srst), .i_cmd_trips(cmd_trips),
      .i_cmd_open(cmd_open), .i_cmd_amps(cmd_amps), .o_trips(trips), .o_tick(tick),
      .o_brk_open(brk_open), .o_brk_closed(brk_closed), .o_current(amps));
   task automatic give_verdict();
      $display("checked %0d failures %0d", checked, failures);
      if (failures == 0 && checked > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask
   // a hang counts as a mismatch
   always @(posedge i_ref_clk)
   begin
      cycles++;
      if (cycles == LIMIT)
      begin
         failures++;
         $display("Error at %0t: timeout", $time);
         give_verdict();
      end
   end
   task automatic cmp_word(input logic [31:0] got, input logic [31:0] exp);
      checked++;
      if (got !== exp)
      begin
         failures++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic cmp_bit(input logic got, input logic exp);
      cmp_word({31'h0, got}, {31'h0, exp});
   endtask
   task automatic settle(input int n);
      repeat (n) @(posedge i_ref_clk);
   endtask
   // write: address and data offered together, each dropped once taken
   task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
      axil.awaddr <= a;
      axil.wdata <= d;
      axil.wstrb <= 4'hf;
      axil.awvalid <= 1'b1;
      axil.wvalid <= 1'b1;
      axil.bready <= 1'b1;
      forever
      begin
         @(posedge i_ref_clk);
         if (!axil.awvalid && !axil.wvalid && rsp.bvalid)
            break;
         if (rsp.awready)
            axil.awvalid <= 1'b0;
         if (rsp.wready)
            axil.wvalid <= 1'b0;
      end
      cmp_word({30'h0, rsp.bresp}, {30'h0, er});
      axil.bready <= 1'b0;
      @(posedge i_ref_clk);
   endtask
   task automatic rd(input logic [7:0] a, output logic [31:0] d, input logic [1:0] er);
      axil.araddr <= a;
      axil.arvalid <= 1'b1;
      axil.rready <= 1'b1;
      forever
      begin
         @(posedge i_ref_clk);
         if (!axil.arvalid && rsp.rvalid)
            break;
         if (rsp.arready)
            axil.arvalid <= 1'b0;
      end
      d = rsp.rdata;
      cmp_word({30'h0, rsp.rresp}, {30'h0, er});
      axil.rready <= 1'b0;
      @(posedge i_ref_clk);
   endtask
   task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
      logic [31:0] d;
      rd(a, d, `BFS_RESP_OKAY);
      cmp_word(d, e);
   endtask
   task automatic st(input logic [1:0] s);
      logic [31:0] d;
      rd(`BFS_OFS_STATUS, d, `BFS_RESP_OKAY);
      cmp_word({30'h0, d[1:0]}, {30'h0, s});
   endtask
   task automatic plant(input logic [2:0] t, input logic op, input logic [15:0] a);
      cmd_trips <= t;
      cmd_open <= op;
      cmd_amps <= a;
   endtask
   task automatic wait_trip();
      int n;
      n = 0;
      while (trip !== 1'b1 && n < 60)
      begin
         @(posedge i_ref_clk);
         n++;
      end
      cmp_bit(n >= 4 && n < 60, 1'b1);
   endtask
   function automatic logic [31:0] ctrl(input logic [1:0] sch, input logic [1:0] trg);
      return {26'h0, trg, sch, 2'b11};
   endfunction
   task automatic t_regs();
      logic [31:0] d;
      rd_chk(`BFS_OFS_CTRL, `BFS_CTRL_RST);
      rd_chk(`BFS_OFS_DELAY, `BFS_DELAY_RST);
      rd_chk(`BFS_OFS_THRESH, `BFS_THRESH_RST);
      rd(8'h1c, d, `BFS_RESP_SLVERR);
      cmp_word(d, 32'h0);
      wr(`BFS_OFS_STATUS, 32'h0000_003f, `BFS_RESP_SLVERR);
      st(`BFS_ST_STANDBY);
      wr(`BFS_OFS_THRESH, 32'h0000_0064, `BFS_RESP_OKAY);
      wr(`BFS_OFS_IRQ_MASK, 32'h0000_0007, `BFS_RESP_OKAY);
      wr(`BFS_OFS_DELAY, 32'h0000_0014, `BFS_RESP_OKAY);
      rd_chk(`BFS_OFS_DELAY, 32'h0000_0014);
   endtask
   // each trigger class alone starts the timer; open position stops it
   task automatic t_class();
      logic [2:0] sel;
      for (int c = 1; c < 4; c++)
      begin
         sel = 3'h1 << (c - 1);
         wr(`BFS_OFS_CTRL, ctrl(`BFS_SCH_POS, c[1:0]), `BFS_RESP_OKAY);
         plant(~sel, 1'b0, 16'h0000);
         settle(4);
         st(`BFS_ST_STANDBY);
         plant(sel, 1'b0, 16'h0000);
         settle(3);
         st(`BFS_ST_RUN);
         plant(sel, 1'b1, 16'h0000);
         settle(6);
         st(`BFS_ST_REJECT);
         plant(3'h0, 1'b1, 16'h0000);
         settle(3);
         st(`BFS_ST_STANDBY);
         plant(3'h0, 1'b0, 16'h0000);
         settle(6);
      end
      cmp_bit(irq, 1'b1);
      wr(`BFS_OFS_IRQ_MASK, 32'h0, `BFS_RESP_OKAY);
      cmp_bit(irq, 1'b0);
      rd_chk(`BFS_OFS_IRQ_STAT, 32'h0000_0003);
      wr(`BFS_OFS_IRQ_STAT, 32'h0000_0007, `BFS_RESP_OKAY);
      rd_chk(`BFS_OFS_IRQ_STAT, 32'h0);
      wr(`BFS_OFS_IRQ_MASK, 32'h0000_0007, `BFS_RESP_OKAY);
   endtask
   task automatic t_cur();
      wr(`BFS_OFS_CTRL, ctrl(`BFS_SCH_POS, `BFS_TRG_ALL), `BFS_RESP_OKAY);
      plant(3'h1, 1'b1, 16'h01f4);
      settle(6);
      st(`BFS_ST_STANDBY);
      wr(`BFS_OFS_CTRL, ctrl(`BFS_SCH_CUR, `BFS_TRG_ALL), `BFS_RESP_OKAY);
      st(`BFS_ST_RUN);
      plant(3'h1, 1'b1, 16'h000a);
      settle(3);
      st(`BFS_ST_REJECT);
      plant(3'h0, 1'b0, 16'h000a);
      settle(6);
      st(`BFS_ST_STANDBY);
      wr(`BFS_OFS_IRQ_STAT, 32'h0000_0007, `BFS_RESP_OKAY);
   endtask
   // expiry with the trigger gone early, then release and acknowledge
   task automatic t_fail();
      wr(`BFS_OFS_DELAY, 32'h0000_0003, `BFS_RESP_OKAY);
      wr(`BFS_OFS_CTRL, ctrl(`BFS_SCH_POS, `BFS_TRG_ALL), `BFS_RESP_OKAY);
      plant(3'h1, 1'b0, 16'h01f4);
      settle(2);
      plant(3'h0, 1'b0, 16'h01f4);
      wait_trip();
      cmp_bit(inhibit, 1'b1);
      cmp_bit(irq, 1'b1);
      st(`BFS_ST_FAIL);
      rd_chk(`BFS_OFS_TIMER, 32'h0);
      settle(8);
      cmp_bit(trip, 1'b1);
      plant(3'h0, 1'b1, 16'h01f4);
      settle(6);
      cmp_bit(trip, 1'b0);
      cmp_bit(inhibit, 1'b1);
      ack <= 1'b1;
      @(posedge i_ref_clk);
      ack <= 1'b0;
      settle(2);
      cmp_bit(inhibit, 1'b0);
      plant(3'h0, 1'b0, 16'h01f4);
      settle(6);
   endtask
   // combined scheme: open position alone does not stop the timer
   task automatic t_both();
      wr(`BFS_OFS_CTRL, ctrl(`BFS_SCH_BOTH, `BFS_TRG_EXT), `BFS_RESP_OKAY);
      plant(3'h4, 1'b0, 16'h01f4);
      settle(2);
      plant(3'h4, 1'b1, 16'h01f4);
      wait_trip();
      plant(3'h7, 1'b1, 16'h000a);
      settle(6);
      cmp_bit(trip, 1'b1);
      plant(3'h0, 1'b1, 16'h01f4);
      settle(6);
      cmp_bit(trip, 1'b1);
      plant(3'h0, 1'b1, 16'h000a);
      settle(4);
      cmp_bit(trip, 1'b0);
      cmp_bit(inhibit, 1'b1);
      wr(`BFS_OFS_CTRL, 32'h0, `BFS_RESP_OKAY);
      settle(2);
      cmp_bit(inhibit, 1'b0);
   endtask
   initial
   begin
      repeat (2) @(posedge i_ref_clk);
      i_srst <= 1'b0;
      t_regs();
      t_class();
      t_cur();
      t_fail();
      t_both();
      give_verdict();
   end
endmodule
bind bfs_top bfs_top_sva i_sva (.i_ref_clk(i_ref_clk), .i_srst(i_srst), .i_ce(i_ce),
   .i_axil(i_axil), .o_axil(o_axil), .i_trips(i_trips), .i_lockout_ack(i_lockout_ack),
   .o_backup_trip(o_backup_trip), .o_close_inhibit(o_close_inhibit), .o_irq(o_irq));
`default_nettype wire
